// ---- hdl/dbm_pkg.sv ----
// Purpose: shared constants for the debug breakpoint-match registers
// Assumes: 4-bit register index, 32-bit register data
// Notes:   indices other than the attribute register are free choices
package dbm_pkg;
   // =====================================================================
   // register indices
   // =====================================================================
   localparam logic [3:0] IDX_CFG_STATUS = 4'h0;
   localparam logic [3:0] IDX_ADDR_HIGH  = 4'h4;
   localparam logic [3:0] IDX_ADDR_LOW   = 4'h5;
   localparam logic [3:0] IDX_ATTR       = 4'h6;
   localparam logic [3:0] IDX_TRIG_DEF   = 4'h7;
   localparam logic [3:0] IDX_PC_VALUE   = 4'h8;
   localparam logic [3:0] IDX_PC_MASK    = 4'h9;
   localparam logic [3:0] IDX_DATA_VALUE = 4'he;
   localparam logic [3:0] IDX_DATA_MASK  = 4'hf;
   // =====================================================================
   // field positions
   // =====================================================================
   localparam int CFG_LOCK_BIT   = 16;
   localparam int ATTR_RW_BIT    = 7;
   localparam int ATTR_IGN_LSB   = 8;
   localparam int TD_RESP_LSB    = 30;
   localparam int TD_EBL_BIT     = 13;
   localparam int TD_EDLW_BIT    = 12;
   localparam int TD_EDWL_BIT    = 11;
   localparam int TD_EDWU_BIT    = 10;
   localparam int TD_EDLL_BIT    = 9;
   localparam int TD_EDLM_BIT    = 8;
   localparam int TD_EDUM_BIT    = 7;
   localparam int TD_EDUU_BIT    = 6;
   localparam int TD_DI_BIT      = 5;
   localparam int TD_EAI_BIT     = 4;
   localparam int TD_EAR_BIT     = 3;
   localparam int TD_EAL_BIT     = 2;
   localparam int TD_EPC_BIT     = 1;
   localparam int TD_PCI_BIT     = 0;
   // =====================================================================
   // reset values and encodings
   // =====================================================================
   localparam logic [31:0] RST_WORD   = 32'h0000_0000;
   localparam logic [1:0]  SIZE_LONG  = 2'h0;
   localparam logic [1:0]  SIZE_BYTE  = 2'h1;
   localparam logic [1:0]  SIZE_WORD  = 2'h2;
   localparam logic [1:0]  RESP_SHOW  = 2'h0;
   localparam logic [1:0]  RESP_HALT  = 2'h1;
   localparam logic [1:0]  RESP_IRQ   = 2'h2;
   localparam logic [1:0]  KIND_ALT   = 2'h1;
endpackage : dbm_pkg

// ---- hdl/dbm_regmem.sv ----
// Purpose: eight-word register store for the match values
// Assumes: one write port, one registered read port
// Notes:   read data appear one clock after the index
module dbm_regmem
(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_we,
   input  wire logic [2:0]  i_waddr,
   input  wire logic [31:0] i_wdata,
   input  wire logic [2:0]  i_raddr,
   output logic      [31:0] o_rdata,
   output logic      [255:0] o_all
);
   logic [31:0] mem_reg [8];
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_word
         always_ff @(posedge i_clk)
         begin
            if (!i_reset_n)
               mem_reg[g] <= dbm_pkg::RST_WORD;
            else if (i_we && i_waddr == 3'(g))
               mem_reg[g] <= i_wdata;
         end
         assign o_all[g*32 +: 32] = mem_reg[g];
      end
   endgenerate
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         o_rdata <= dbm_pkg::RST_WORD;
      else
         o_rdata <= mem_reg[i_raddr];
   end
endmodule : dbm_regmem

// ---- hdl/dbm_match.sv ----
// Purpose: breakpoint-match registers and comparators of a debug unit
// Assumes: all inputs synchronous to I_CLK_SYS; one bus cycle per valid strobe
// Notes:   trigger sequencing and status reporting live outside this block

module dbm_match
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RESET_N,
   input  wire logic        I_DBG_WR,
   input  wire logic        I_DBG_RD,
   input  wire logic [3:0]  I_DBG_IDX,
   input  wire logic [31:0] I_DBG_WDATA,
   input  wire logic        I_MEM_CMD,
   input  wire logic        I_MEM_CMD_WR,
   input  wire logic [31:0] I_MEM_CMD_ADDR,
   input  wire logic [31:0] I_MEM_CMD_DATA,
   input  wire logic        I_CORE_WR,
   input  wire logic        I_CORE_SUPV,
   input  wire logic [3:0]  I_CORE_IDX,
   input  wire logic [31:0] I_CORE_WDATA,
   input  wire logic        I_BUS_VALID,
   input  wire logic [31:0] I_BUS_ADDR,
   input  wire logic        I_BUS_RW,
   input  wire logic [1:0]  I_BUS_SIZE,
   input  wire logic [1:0]  I_BUS_KIND,
   input  wire logic [2:0]  I_BUS_MOD,
   input  wire logic [31:0] I_BUS_DATA,
   input  wire logic        I_PC_VALID,
   input  wire logic [31:0] I_PC,
   output logic      [31:0] O_DBG_RDATA,
   output logic             O_DBG_RVALID,
   output logic      [1:0]  O_MEM_KIND,
   output logic      [2:0]  O_MEM_MOD,
   output logic             O_MEM_ALT_MASTER,
   output logic             O_ADDR_MATCH,
   output logic             O_PC_MATCH,
   output logic             O_DATA_MATCH,
   output logic      [1:0]  O_TRIG_RESP,
   output logic      [13:0] O_LEVEL1_DEF,
   output logic      [13:0] O_LEVEL2_DEF,
   output logic             O_CORE_LOCKED
);
   // =====================================================================
   // write path selection
   // =====================================================================
   logic [31:0] cfg_reg;
   logic [31:0] trig_reg;
   logic [255:0] words;
   logic [31:0] mem_rdata;
   logic        rd_pend_reg;
   logic        rd_word_reg;
   logic [31:0] rd_direct_reg;
   logic        lock;
   logic        core_ok;
   logic        dbg_wr_ok;
   logic [3:0]  wr_idx;
   logic [31:0] wr_data;
   logic        wr_any;
   logic        wr_bank;
   logic        mem_we;
   logic [2:0]  mem_waddr;
   logic [31:0] mem_wdata;
   logic        idx_bank;

   assign lock      = cfg_reg[dbm_pkg::CFG_LOCK_BIT];
   assign core_ok   = I_CORE_WR && I_CORE_SUPV && !lock;
   assign dbg_wr_ok = I_DBG_WR;
   // debug port has priority; concurrent access is the user's fault
   assign wr_idx    = dbg_wr_ok ? I_DBG_IDX : I_CORE_IDX;
   assign wr_data   = dbg_wr_ok ? I_DBG_WDATA : I_CORE_WDATA;
   assign wr_any    = dbg_wr_ok || core_ok;
   assign wr_bank   = wr_idx[3] || (wr_idx[2:1] != 2'h0 && wr_idx != dbm_pkg::IDX_TRIG_DEF);
   assign idx_bank  = wr_bank;

   // word store slots: index 4..6 -> 4..6 slot, 8,9 -> 0,1, e,f -> 2,3
   function automatic logic [2:0] slot_of(input logic [3:0] idx);
      logic [2:0] s;
      s = 3'h7;
      case (idx)
         dbm_pkg::IDX_PC_VALUE:   s = 3'h0;
         dbm_pkg::IDX_PC_MASK:    s = 3'h1;
         dbm_pkg::IDX_DATA_VALUE: s = 3'h2;
         dbm_pkg::IDX_DATA_MASK:  s = 3'h3;
         dbm_pkg::IDX_ADDR_HIGH:  s = 3'h4;
         dbm_pkg::IDX_ADDR_LOW:   s = 3'h5;
         dbm_pkg::IDX_ATTR:       s = 3'h6;
         default:                 s = 3'h7;
      endcase
      return s;
   endfunction : slot_of

   // =====================================================================
   // memory commands overwrite the shared words, one per cycle
   // =====================================================================
   typedef enum logic [2:0]
   {
      DBM_IDLE = 3'b001,
      DBM_ADDR = 3'b010,
      DBM_DATA = 3'b100
   } dbm_state_t;
   dbm_state_t state_reg;
   dbm_state_t state_next;
   logic       cmd_wr_reg;
   logic [31:0] cmd_data_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         DBM_IDLE: if (I_MEM_CMD) state_next = DBM_ADDR;
         DBM_ADDR: state_next = cmd_wr_reg ? DBM_DATA : DBM_IDLE;
         DBM_DATA: state_next = DBM_IDLE;
         default:  state_next = DBM_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RESET_N)
      begin
         state_reg    <= DBM_IDLE;
         cmd_wr_reg   <= 1'b0;
         cmd_data_reg <= dbm_pkg::RST_WORD;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == DBM_IDLE && I_MEM_CMD)
         begin
            cmd_wr_reg   <= I_MEM_CMD_WR;
            cmd_data_reg <= I_MEM_CMD_DATA;
         end
      end
   end

   logic [31:0] cmd_addr_reg;
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RESET_N)
         cmd_addr_reg <= dbm_pkg::RST_WORD;
      else if (state_reg == DBM_IDLE && I_MEM_CMD)
         cmd_addr_reg <= I_MEM_CMD_ADDR;
   end

   // memory-command writes take the store in their state; register writes to the store in those cycles are lost
   assign mem_we    = (state_reg != DBM_IDLE) || (wr_any && idx_bank);
   assign mem_waddr = (state_reg == DBM_ADDR) ? slot_of(dbm_pkg::IDX_ADDR_HIGH) :
                      (state_reg == DBM_DATA) ? slot_of(dbm_pkg::IDX_DATA_VALUE) :
                      slot_of(wr_idx);
   assign mem_wdata = (state_reg == DBM_ADDR) ? cmd_addr_reg :
                      (state_reg == DBM_DATA) ? cmd_data_reg : wr_data;

   // =====================================================================
   // control words
   // =====================================================================
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RESET_N)
      begin
         cfg_reg  <= dbm_pkg::RST_WORD;
         trig_reg <= dbm_pkg::RST_WORD;
      end
      else
      begin
         // only the debug port may move the lock bit
         if (dbg_wr_ok && I_DBG_IDX == dbm_pkg::IDX_CFG_STATUS)
            cfg_reg <= I_DBG_WDATA;
         if (wr_any && wr_idx == dbm_pkg::IDX_TRIG_DEF)
            trig_reg <= wr_data;
      end
   end

   dbm_regmem u_store
   (
      .i_clk     (I_CLK_SYS),
      .i_reset_n (I_RESET_N),
      .i_we      (mem_we),
      .i_waddr   (mem_waddr),
      .i_wdata   (mem_wdata),
      .i_raddr   (slot_of(I_DBG_IDX)),
      .o_rdata   (mem_rdata),
      .o_all     (words)
   );

   // =====================================================================
   // debug port read
   // =====================================================================
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RESET_N)
      begin
         rd_pend_reg   <= 1'b0;
         rd_word_reg   <= 1'b0;
         rd_direct_reg <= dbm_pkg::RST_WORD;
      end
      else
      begin
         rd_pend_reg   <= I_DBG_RD;
         rd_word_reg   <= slot_of(I_DBG_IDX) != 3'h7;
         rd_direct_reg <= (I_DBG_IDX == dbm_pkg::IDX_CFG_STATUS) ? cfg_reg :
                          (I_DBG_IDX == dbm_pkg::IDX_TRIG_DEF) ? trig_reg :
                          dbm_pkg::RST_WORD;
      end
   end
   // attribute word stores all 32 bits; only 15:0 take part in matching
   logic [31:0] rd_word;
   assign rd_word = rd_word_reg ? mem_rdata : rd_direct_reg;

   // =====================================================================
   // comparators
   // =====================================================================
   logic [31:0] pc_val, pc_msk, d_val, d_msk, a_hi, a_lo;
   logic [15:0] attr;
   logic        in_range, at_low, attr_hit, addr_hit, pc_eq, pc_hit, data_eq, data_hit;
   logic [7:0]  lane_b;
   logic [7:0]  val_b;
   logic [7:0]  msk_b;
   logic [15:0] lane_w, val_w, msk_w;
   logic [7:0]  bus_attr;
   logic        byte_en, word_en, long_en;

   assign pc_val = words[0*32 +: 32];
   assign pc_msk = words[1*32 +: 32];
   assign d_val  = words[2*32 +: 32];
   assign d_msk  = words[3*32 +: 32];
   assign a_hi   = words[4*32 +: 32];
   assign a_lo   = words[5*32 +: 32];
   assign attr   = words[6*32 +: 16];

   assign in_range = (I_BUS_ADDR >= a_lo) && (I_BUS_ADDR <= a_hi);
   assign at_low   = I_BUS_ADDR == a_lo;
   // bus attributes packed like the attribute word low byte
   assign bus_attr = {I_BUS_RW, I_BUS_SIZE, I_BUS_KIND, I_BUS_MOD};
   // codes are compared bitwise; meanings of the kind/modifier codes are the bus's
   assign attr_hit = ((bus_attr ^ attr[7:0]) & ~attr[15:8]) == 8'h00;
   assign addr_hit = attr_hit &&
                     ((trig_reg[dbm_pkg::TD_EAR_BIT] && in_range) ||
                      (trig_reg[dbm_pkg::TD_EAI_BIT] && !in_range) ||
                      (trig_reg[dbm_pkg::TD_EAL_BIT] && at_low));

   assign pc_eq  = ((I_PC ^ pc_val) & ~pc_msk) == 32'h0000_0000;
   assign pc_hit = trig_reg[dbm_pkg::TD_EPC_BIT] &&
                   (pc_eq ^ trig_reg[dbm_pkg::TD_PCI_BIT]);

   // operand lane by address and size, compared against the value's low bits
   assign lane_b = (I_BUS_ADDR[1:0] == 2'h0) ? I_BUS_DATA[31:24] :
                   (I_BUS_ADDR[1:0] == 2'h1) ? I_BUS_DATA[23:16] :
                   (I_BUS_ADDR[1:0] == 2'h2) ? I_BUS_DATA[15:8] :
                   I_BUS_DATA[7:0];
   assign lane_w = I_BUS_ADDR[1] ? I_BUS_DATA[15:0] : I_BUS_DATA[31:16];
   assign val_b  = d_val[7:0];
   assign msk_b  = d_msk[7:0];
   assign val_w  = d_val[15:0];
   assign msk_w  = d_msk[15:0];
   // byte lane enables run upper-upper to lower-lower with rising bit index
   assign byte_en = I_BUS_SIZE == dbm_pkg::SIZE_BYTE &&
                    trig_reg[dbm_pkg::TD_EDUU_BIT + int'(I_BUS_ADDR[1:0])];
   assign word_en = I_BUS_SIZE == dbm_pkg::SIZE_WORD &&
                    (I_BUS_ADDR[1] ? trig_reg[dbm_pkg::TD_EDWL_BIT]
                                   : trig_reg[dbm_pkg::TD_EDWU_BIT]);
   assign long_en = I_BUS_SIZE == dbm_pkg::SIZE_LONG && trig_reg[dbm_pkg::TD_EDLW_BIT];
   assign data_eq = byte_en ? (((lane_b ^ val_b) & ~msk_b) == 8'h00) :
                    word_en ? (((lane_w ^ val_w) & ~msk_w) == 16'h0000) :
                    (((I_BUS_DATA ^ d_val) & ~d_msk) == 32'h0000_0000);
   assign data_hit = (byte_en || word_en || long_en) &&
                     (data_eq ^ trig_reg[dbm_pkg::TD_DI_BIT]);

   // =====================================================================
   // outputs
   // =====================================================================
   logic enabled;
   assign enabled = trig_reg[dbm_pkg::TD_EBL_BIT];

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RESET_N)
      begin
         O_ADDR_MATCH     <= 1'b0;
         O_PC_MATCH       <= 1'b0;
         O_DATA_MATCH     <= 1'b0;
         O_DBG_RDATA      <= dbm_pkg::RST_WORD;
         O_DBG_RVALID     <= 1'b0;
         O_MEM_KIND       <= 2'h0;
         O_MEM_MOD        <= 3'h0;
         O_MEM_ALT_MASTER <= 1'b0;
         O_TRIG_RESP      <= dbm_pkg::RESP_SHOW;
         O_LEVEL1_DEF     <= 14'h0000;
         O_LEVEL2_DEF     <= 14'h0000;
         O_CORE_LOCKED    <= 1'b0;
      end
      else
      begin
         O_ADDR_MATCH     <= enabled && I_BUS_VALID && addr_hit;
         O_PC_MATCH       <= enabled && I_PC_VALID && pc_hit;
         O_DATA_MATCH     <= enabled && I_BUS_VALID && data_hit;
         O_DBG_RDATA      <= rd_pend_reg ? rd_word : O_DBG_RDATA;
         O_DBG_RVALID     <= rd_pend_reg;
         O_MEM_KIND       <= attr[4:3];
         O_MEM_MOD        <= attr[2:0];
         O_MEM_ALT_MASTER <= attr[4:3] == dbm_pkg::KIND_ALT;
         O_TRIG_RESP      <= trig_reg[dbm_pkg::TD_RESP_LSB +: 2];
         O_LEVEL1_DEF     <= trig_reg[13:0];
         O_LEVEL2_DEF     <= trig_reg[29:16];
         O_CORE_LOCKED    <= lock;
      end
   end

   // =====================================================================
   // checks
   // =====================================================================
   sequence core_try_s;
      I_CORE_WR && !I_DBG_WR && I_CORE_IDX == dbm_pkg::IDX_TRIG_DEF;
   endsequence
   lock_blocks_a : assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      core_try_s and lock |=> trig_reg == $past(trig_reg))
      else $error("locked core write changed trigger definition");
   core_write_a : assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      core_try_s and I_CORE_SUPV && !lock |=> trig_reg == $past(I_CORE_WDATA))
      else $error("supervisor core write lost");
   read_latency_a : assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      I_DBG_RD |-> ##2 O_DBG_RVALID)
      else $error("debug read answer not two cycles later");
   match_pulse_a : assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      !I_PC_VALID |=> !O_PC_MATCH)
      else $error("pc match without pc update");
   reset_clear_a : assert property (@(posedge I_CLK_SYS)
      !I_RESET_N |=> trig_reg == dbm_pkg::RST_WORD && !O_ADDR_MATCH)
      else $error("trigger definition not cleared by reset");
   alt_master_a : assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      O_MEM_ALT_MASTER == (O_MEM_KIND == dbm_pkg::KIND_ALT))
      else $error("alternate master flag wrong");
   sequence mem_cmd_s;
      state_reg == DBM_IDLE && I_MEM_CMD ##1 1'b1;
   endsequence
   cmd_overwrite_a : assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      mem_cmd_s |=> a_hi == $past(cmd_addr_reg))
      else $error("memory command did not overwrite high bound");
   pc_mask_a : assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      I_PC_VALID && enabled && trig_reg[dbm_pkg::TD_EPC_BIT] &&
      !trig_reg[dbm_pkg::TD_PCI_BIT] && pc_msk == 32'hffff_ffff |=> O_PC_MATCH)
      else $error("fully masked pc did not match");
endmodule : dbm_match

// ---- verif/dbm_far_model.sv ----
// Purpose: far-side model that drives core bus cycles and pc updates
// Assumes: the bench requests one access at a time
// Notes:   released lines show the inverse of the last value
module dbm_far_model
(
   input  wire logic        i_clk,
   input  wire logic        i_bus_req,
   input  wire logic [39:0] i_bus,
   input  wire logic [31:0] i_data,
   input  wire logic        i_pc_req,
   input  wire logic [31:0] i_pc,
   output logic             o_valid,
   output logic      [39:0] o_bus,
   output logic      [31:0] o_data,
   output logic             o_pc_valid,
   output logic      [31:0] o_pc
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================================
   // one-cycle accesses, launched after the falling edge
   // =====================================================================
   initial
   begin
      o_bus = '0;
      o_data = '0;
      o_pc = '0;
   end
   always @(negedge i_clk)
   begin
      o_valid    <= i_bus_req;
      o_bus      <= i_bus_req ? i_bus : ~o_bus;
      o_data     <= i_bus_req ? i_data : ~o_data;
      o_pc_valid <= i_pc_req;
      o_pc       <= i_pc_req ? i_pc : ~o_pc;
   end
endmodule : dbm_far_model

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the breakpoint-match registers
// Assumes: inputs change at the falling edge
// Notes:   random values from a fixed seed
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, dwr, drd, mcmd, cwr, csupv, rbus, rpc, bv, pv, rv, am, pm, dm, alt, lck;
   logic        mwr;
   logic [3:0]  didx, cidx;
   logic [31:0] dwd, maddr, mdata, cwd, rdat, rbd, mbd, rpcv, mpc, v, mk, lo, d, c, lm;
   logic [39:0] rb, mb;
   logic [1:0]  kd, trs;
   logic [2:0]  md;
   logic [13:0] l1, l2;
   logic [1:0]  kk [3] = '{2'h0, 2'h2, 2'h3};
   logic [7:0]  fl [4] = '{8'h80, 8'h20, 8'h08, 8'h01};
   int fail_count, n_compared, cyc;
   dbm_match DUT
   (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_DBG_WR(dwr), .I_DBG_RD(drd), .I_DBG_IDX(didx),
    .I_DBG_WDATA(dwd), .I_MEM_CMD(mcmd), .I_MEM_CMD_WR(mwr), .I_MEM_CMD_ADDR(maddr),
    .I_MEM_CMD_DATA(mdata), .I_CORE_WR(cwr), .I_CORE_SUPV(csupv), .I_CORE_IDX(cidx),
    .I_CORE_WDATA(cwd), .I_BUS_VALID(bv), .I_BUS_ADDR(mb[39:8]), .I_BUS_RW(mb[7]),
    .I_BUS_SIZE(mb[6:5]), .I_BUS_KIND(mb[4:3]), .I_BUS_MOD(mb[2:0]), .I_BUS_DATA(mbd),
    .I_PC_VALID(pv), .I_PC(mpc), .O_DBG_RDATA(rdat), .O_DBG_RVALID(rv), .O_MEM_KIND(kd),
    .O_MEM_MOD(md), .O_MEM_ALT_MASTER(alt), .O_ADDR_MATCH(am), .O_PC_MATCH(pm),
    .O_DATA_MATCH(dm), .O_TRIG_RESP(trs), .O_LEVEL1_DEF(l1), .O_LEVEL2_DEF(l2),
    .O_CORE_LOCKED(lck));
   dbm_far_model far
   (.i_clk(clk), .i_bus_req(rbus), .i_bus(rb), .i_data(rbd), .i_pc_req(rpc), .i_pc(rpcv),
    .o_valid(bv), .o_bus(mb), .o_data(mbd), .o_pc_valid(pv), .o_pc(mpc));
   // =====================================================================
   // checking and bus tasks
   // =====================================================================
   function automatic logic [31:0] lane_mask(input int a);
      return 32'hff00_0000 >> (8 * a);
   endfunction : lane_mask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic dw(input logic [3:0] i, input logic [31:0] x);
      @(negedge clk);
      dwr = 1'b1;
      didx = i;
      dwd = x;
      @(negedge clk);
      dwr = 1'b0;
   endtask : dw
   task automatic cw(input logic [3:0] i, input logic [31:0] x, input logic s);
      @(negedge clk);
      cwr = 1'b1;
      cidx = i;
      cwd = x;
      csupv = s;
      @(negedge clk);
      cwr = 1'b0;
   endtask : cw
   task automatic rdchk(input logic [3:0] i, input logic [31:0] exp);
      logic [31:0] r;
      @(negedge clk);
      drd = 1'b1;
      didx = i;
      @(negedge clk);
      drd = 1'b0;
      r = 32'hdead_beef;
      repeat (4)
      begin
         if (rv === 1'b1)
            r = rdat;
         @(negedge clk);
      end
      chk("read_data", r, exp);
   endtask : rdchk
   task automatic bus(input logic [39:0] b, input logic [31:0] x, input logic [31:0] ea,
                      input logic [31:0] ed);
      logic [31:0] na, nd;
      @(negedge clk);
      rb <= b;
      rbd <= x;
      rbus <= 1'b1;
      @(negedge clk);
      rbus <= 1'b0;
      na = 0;
      nd = 0;
      repeat (4)
      begin
         @(posedge clk);
         #1;
         na = na + am;
         nd = nd + dm;
      end
      chk("addr_match", na, ea);
      chk("data_match", nd, ed);
   endtask : bus
   task automatic pc(input logic [31:0] p, input logic [31:0] ep);
      logic [31:0] np;
      @(negedge clk);
      rpcv <= p;
      rpc <= 1'b1;
      @(negedge clk);
      rpc <= 1'b0;
      np = 0;
      repeat (4)
      begin
         @(posedge clk);
         #1;
         np = np + pm;
      end
      chk("pc_match", np, ep);
   endtask : pc
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         fail_count++;
         complete_run();
      end
   end
   // =====================================================================
   // main sequence
   // =====================================================================
   initial
   begin
      void'($urandom(32'h566a));
      {rst_n, dwr, drd, mcmd, mwr, cwr, csupv, rbus, rpc} = '0;
      {didx, cidx, dwd, maddr, mdata, cwd, rb, rbd, rpcv} = '0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      chk("trig_resp", trs, 0);
      chk("level1", l1, 0);
      rdchk(dbm_pkg::IDX_TRIG_DEF, 0);
      bus({$urandom, 8'h0}, $urandom, 0, 0);
      pc($urandom, 0);
      for (int k = 4; k < 8; k++)
      begin
         v = $urandom;
         dw(4'(k), v);
         rdchk(4'(k), v);
      end
      dw(4'h3, $urandom);
      rdchk(4'h3, 0);
      for (int r = 0; r < 3; r++)
      begin
         v = {2'(r), 30'($urandom)};
         dw(4'h7, v);
         repeat (2) @(negedge clk);
         chk("trig_resp", trs, v[31:30]);
         chk("level1", l1, v[13:0]);
         chk("level2", l2, v[29:16]);
      end
      for (int k = 0; k < 4; k++)
      begin
         v = {27'($urandom), 2'(k), 3'($urandom)};
         dw(4'h6, v);
         repeat (2) @(negedge clk);
         chk("mem_attr", {kd, md}, v[4:0]);
         chk("alt_master", alt, k == 1);
      end
      cw(4'h6, 32'h0000_1234, 1'b1);
      rdchk(4'h6, 32'h0000_1234);
      cw(4'h6, 32'h0000_5678, 1'b0);
      rdchk(4'h6, 32'h0000_1234);
      cw(4'h7, 32'h4000_0000, 1'b1);
      repeat (2) @(negedge clk);
      chk("trig_resp", trs, 1);
      dw(4'h0, 32'h0001_0000);
      repeat (2) @(negedge clk);
      chk("locked", lck, 1);
      cw(4'h6, 32'h0000_9abc, 1'b1);
      rdchk(4'h6, 32'h0000_1234);
      cw(4'h7, 32'h8000_0000, 1'b1);
      repeat (2) @(negedge clk);
      chk("trig_resp", trs, 1);
      dw(4'h0, 32'h0);
      lo = $urandom & 32'h7fff_fff0;
      dw(4'h5, lo);
      dw(4'h4, lo + 32'h100);
      dw(4'h6, 32'h0000_ff00);
      dw(4'h7, 32'h0000_2008);
      bus({lo, 8'h0}, 0, 1, 0);
      bus({lo + 32'h100, 8'h0}, 0, 1, 0);
      bus({lo + 32'h101, 8'h0}, 0, 0, 0);
      dw(4'h7, 32'h0000_2010);
      bus({lo - 32'h1, 8'h0}, 0, 1, 0);
      bus({lo + 32'h10, 8'h0}, 0, 0, 0);
      dw(4'h7, 32'h0000_2004);
      for (int n = 0; n < 24; n++)
      begin
         c = {24'h0, n[0], 2'(n % 3), kk[n / 8], 3'(n)};
         dw(4'h6, c);
         bus({lo, c[7:0]}, 0, 1, 0);
         bus({lo, c[7:0] ^ fl[n % 4]}, 0, 0, 0);
         dw(4'h6, c | {16'h0, fl[n % 4], 8'h0});
         bus({lo, c[7:0] ^ fl[n % 4]}, 0, 1, 0);
      end
      v = $urandom;
      mk = $urandom & 32'hffff_fffe;
      dw(4'h7, 32'h0000_3000);
      dw(4'he, v);
      dw(4'hf, mk);
      d = v ^ ($urandom & mk);
      bus({lo, 8'h0}, d, 0, 1);
      bus({lo, 8'h0}, d ^ 32'h1, 0, 0);
      dw(4'hf, 32'h0);
      for (int a = 0; a < 3; a++)
      begin
         lm = lane_mask(a);
         dw(4'h7, 32'h0000_2000 | (32'h40 << a));
         d = ($urandom & ~lm) | ({4{v[7:0]}} & lm);
         bus({lo | 32'(a), 8'h20}, d, 0, 1);
         bus({lo | 32'(a), 8'h20}, d ^ (lm & 32'h0101_0101), 0, 0);
      end
      dw(4'h7, 32'h0000_2002);
      dw(4'h8, v);
      dw(4'h9, mk);
      d = v ^ ($urandom & mk);
      pc(d, 1);
      pc(d ^ 32'h1, 0);
      dw(4'h9, 32'hffff_ffff);
      pc($urandom, 1);
      for (int w = 0; w < 2; w++)
      begin
         maddr = $urandom;
         mdata = $urandom;
         @(negedge clk);
         mcmd = 1'b1;
         mwr = w[0];
         @(negedge clk);
         mcmd = 1'b0;
         repeat (4) @(negedge clk);
         rdchk(4'h4, maddr);
         rdchk(4'he, (w == 1) ? mdata : v);
      end
      dw(4'h7, 32'h0000_3000);
      bus({lo, 8'h0}, mdata, 0, 1);
      complete_run();
   end
endmodule : testbench
